//--- verilog/ipr_resolver.sv
// Two-level interrupt priority resolver with pending flags and nesting.
// Assumes the core acknowledges only while irq_req is high and returns in order.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module ipr_resolver #(
   parameter int unsigned NUM_SRC = 19
) (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic [7:0]            addr,
   input  wire logic [7:0]            wdata,
   input  wire logic                  wr,
   input  wire logic                  rd,
   input  wire logic                  bit_wr,
   input  wire logic [2:0]            bit_num,
   input  wire logic                  bit_val,
   output logic      [7:0]            rdata,
   input  wire logic [NUM_SRC-1:0]    src_event,
   input  wire logic [NUM_SRC-1:0]    src_enable,
   input  wire logic                  timer2_overflow_flag,
   input  wire logic                  timer2_reload_flag,
   input  wire logic                  serial0_receive_flag,
   input  wire logic                  serial0_transmit_flag,
   input  wire logic                  vec_ack,
   input  wire logic                  ret_done,
   output logic                       irq_req,
   output logic      [4:0]            irq_vector,
   output logic                       irq_high
);
   if (NUM_SRC != ipr_pkg::NUM_SRC) begin : g_bad_num
      $error("NUM_SRC must equal the fixed source count");
   end

   typedef struct packed {
      logic [7:0]         main;
      logic [7:0]         ext;
      logic [7:0]         periph;
      logic [NUM_SRC-1:0] pend;
      logic               srv_low;
      logic               srv_high;
      logic [7:0]         rdata;
      logic               req;
      logic [4:0]         vector;
      logic               high;
   } ipr_state_t;

   ipr_state_t st_q;
   ipr_state_t st_d;

   // Level bit of a source
   function automatic logic level_of(input int unsigned src, input logic [7:0] m,
                                     input logic [7:0] e, input logic [7:0] p);
      logic lv;
      lv = 1'b0;
      case (src)
         ipr_pkg::S_EXT0: lv = m[ipr_pkg::ext0_level_bit];
         ipr_pkg::S_T0:   lv = m[ipr_pkg::timer0_level_bit];
         ipr_pkg::S_EXT1: lv = m[ipr_pkg::ext1_level_bit];
         ipr_pkg::S_T1:   lv = m[ipr_pkg::timer1_level_bit];
         ipr_pkg::S_SER0: lv = m[ipr_pkg::serial0_level_bit];
         ipr_pkg::S_T2:   lv = m[ipr_pkg::timer2_level_bit];
         ipr_pkg::S_EXT2: lv = e[ipr_pkg::ext2_level_bit];
         ipr_pkg::S_EXT3: lv = e[ipr_pkg::ext3_level_bit];
         ipr_pkg::S_EXT4: lv = e[ipr_pkg::ext4_level_bit];
         ipr_pkg::S_EXT5: lv = e[ipr_pkg::ext5_level_bit];
         ipr_pkg::S_EXT6: lv = e[ipr_pkg::ext6_level_bit];
         ipr_pkg::S_WDT:  lv = p[ipr_pkg::P_WDT];
         ipr_pkg::S_ADC:  lv = p[ipr_pkg::P_ADC];
         ipr_pkg::S_IFC:  lv = p[ipr_pkg::P_IFC];
         ipr_pkg::S_SER2: lv = p[ipr_pkg::P_S2];
         ipr_pkg::S_SER1: lv = p[ipr_pkg::P_S1];
         ipr_pkg::S_T3:   lv = p[ipr_pkg::P_T3];
         ipr_pkg::S_T4,
         ipr_pkg::S_T5:   lv = p[ipr_pkg::P_T4];
         default:         lv = 1'b0;
      endcase
      return lv;
   endfunction : level_of

   logic [NUM_SRC-1:0] req_vec;
   logic               hit_hi;
   logic               hit_lo;
   logic [4:0]         sel_hi;
   logic [4:0]         sel_lo;
   logic [7:0]         wr_val;
   logic               lvl;

   always_comb begin
      st_d   = st_q;
      wr_val = wdata;
      hit_hi = 1'b0;
      hit_lo = 1'b0;
      sel_hi = 5'h0_0;
      sel_lo = 5'h0_0;
      lvl    = 1'b0;
      // Whole-byte writes; reserved bits stay zero
      if (wr) begin
         case (addr)
            ipr_pkg::ADDR_MAIN:   st_d.main   = wdata & ipr_pkg::MASK_MAIN;
            ipr_pkg::ADDR_EXT:    st_d.ext    = wdata & ipr_pkg::MASK_EXT;
            ipr_pkg::ADDR_PERIPH: st_d.periph = wdata & ipr_pkg::MASK_PERIPH;
            default: ;
         endcase
      end
      // Single-bit set or clear of the main register
      if (bit_wr && addr == ipr_pkg::ADDR_MAIN) begin
         wr_val          = st_q.main;
         wr_val[bit_num] = bit_val;
         st_d.main       = wr_val & ipr_pkg::MASK_MAIN;
      end
      // Read data valid in the following cycle only
      st_d.rdata = 8'h0_0;
      if (rd) begin
         case (addr)
            ipr_pkg::ADDR_MAIN:   st_d.rdata = st_q.main;
            ipr_pkg::ADDR_EXT:    st_d.rdata = st_q.ext;
            ipr_pkg::ADDR_PERIPH: st_d.rdata = st_q.periph;
            ipr_pkg::ADDR_STATUS: begin
               st_d.rdata[ipr_pkg::ST_HIGH_BIT] = st_q.srv_high;
               st_d.rdata[ipr_pkg::ST_LOW_BIT]  = st_q.srv_low;
               st_d.rdata[4:0]                  = st_q.vector;
            end
            default: st_d.rdata = 8'h0_0;
         endcase
      end
      // Return from service closes the innermost level
      if (ret_done) begin
         if (st_q.srv_high) begin
            st_d.srv_high = 1'b0;
         end else begin
            st_d.srv_low = 1'b0;
         end
      end
      // Vectoring clears the taken flag; t4 before t5 in the shared slot
      if (vec_ack && st_q.req) begin
         if (st_q.high) begin
            st_d.srv_high = 1'b1;
         end else begin
            st_d.srv_low = 1'b1;
         end
         st_d.pend[st_q.vector] = 1'b0;
      end
      // New events win over the clear in the same cycle
      for (int unsigned i = 0; i < NUM_SRC; i++) begin
         if (src_event[i] && i != ipr_pkg::S_SER0 && i != ipr_pkg::S_T2) begin
            st_d.pend[i] = 1'b1;
         end
      end
      // Requests from the updated state
      req_vec                 = st_d.pend & src_enable;
      req_vec[ipr_pkg::S_SER0] = (serial0_receive_flag | serial0_transmit_flag)
                                & src_enable[ipr_pkg::S_SER0];
      req_vec[ipr_pkg::S_T2]   = (timer2_overflow_flag | timer2_reload_flag)
                                & src_enable[ipr_pkg::S_T2];
      // Lowest index wins within each level
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         lvl = level_of(i, st_d.main, st_d.ext, st_d.periph);
         if (req_vec[i] && lvl) begin
            hit_hi = 1'b1;
            sel_hi = 5'(i);
         end
         if (req_vec[i] && !lvl) begin
            hit_lo = 1'b1;
            sel_lo = 5'(i);
         end
      end
      // Offer only what may nest over the service in progress
      st_d.req    = 1'b0;
      st_d.high   = 1'b0;
      st_d.vector = st_q.vector;
      if (!st_d.srv_high) begin
         if (hit_hi) begin
            st_d.req    = 1'b1;
            st_d.high   = 1'b1;
            st_d.vector = sel_hi;
         end else if (hit_lo && !st_d.srv_low) begin
            st_d.req    = 1'b1;
            st_d.vector = sel_lo;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata      = st_q.rdata;
   assign irq_req    = st_q.req;
   assign irq_vector = st_q.vector;
   assign irq_high   = st_q.high;
endmodule : ipr_resolver

//--- inc/ipr_pkg.sv
// Constants for the two-level interrupt priority resolver.
// Assumes an 8-bit special-function register port and a two-level vectoring core.
// Notes on behaviour
// - Priority bit clear low, set high
// - No nesting at same or lower level
// - Fixed order only breaks simultaneous ties
// - Fixed order ext0 first, timer4/5 last
// - Main register bits five to zero used
// - Ext register bits four to zero used
// - Main register at B8, bit access too
// - Peripheral register at C1, bit7 reserved
// - Pending flag set by event, cleared vectoring; serial0, timer2 request from their own flags
package ipr_pkg;
   localparam int unsigned NUM_SRC = 19;
   localparam int unsigned SRC_W   = 5;
   // Register addresses
   localparam logic [7:0] ADDR_EXT    = 8'h0B1;
   localparam logic [7:0] ADDR_MAIN   = 8'h0B8;
   localparam logic [7:0] ADDR_PERIPH = 8'h0C1;
   localparam logic [7:0] ADDR_STATUS = 8'h0C3;
   // Implemented bit masks; reserved bits read zero
   localparam logic [7:0] MASK_MAIN   = 8'h003F;
   localparam logic [7:0] MASK_EXT    = 8'h001F;
   localparam logic [7:0] MASK_PERIPH = 8'h007F;
   localparam logic [7:0] RESET_VAL   = 8'h0000;
   // Status register fields
   localparam int unsigned ST_HIGH_BIT = 7;
   localparam int unsigned ST_LOW_BIT  = 6;
   // Source indices in fixed arbitration order
   localparam int unsigned S_EXT0 = 0;
   localparam int unsigned S_T0   = 1;
   localparam int unsigned S_EXT1 = 2;
   localparam int unsigned S_T1   = 3;
   localparam int unsigned S_SER0 = 4;
   localparam int unsigned S_T2   = 5;
   localparam int unsigned S_WDT  = 6;
   localparam int unsigned S_IFC  = 7;
   localparam int unsigned S_ADC  = 8;
   localparam int unsigned S_EXT2 = 9;
   localparam int unsigned S_EXT3 = 10;
   localparam int unsigned S_EXT4 = 11;
   localparam int unsigned S_SER1 = 12;
   localparam int unsigned S_SER2 = 13;
   localparam int unsigned S_EXT5 = 14;
   localparam int unsigned S_EXT6 = 15;
   localparam int unsigned S_T3   = 16;
   localparam int unsigned S_T4   = 17;
   localparam int unsigned S_T5   = 18;
   // Main register bit positions
   localparam int unsigned ext0_level_bit    = 0;
   localparam int unsigned timer0_level_bit  = 1;
   localparam int unsigned ext1_level_bit    = 2;
   localparam int unsigned timer1_level_bit  = 3;
   localparam int unsigned serial0_level_bit = 4;
   localparam int unsigned timer2_level_bit  = 5;
   // Ext register bit positions
   localparam int unsigned ext2_level_bit = 0;
   localparam int unsigned ext3_level_bit = 1;
   localparam int unsigned ext4_level_bit = 2;
   localparam int unsigned ext5_level_bit = 3;
   localparam int unsigned ext6_level_bit = 4;
   // Peripheral register bit positions
   localparam int unsigned P_T3  = 0;
   localparam int unsigned P_T4  = 1;
   localparam int unsigned P_S1  = 2;
   localparam int unsigned P_S2  = 3;
   localparam int unsigned P_IFC = 4;
   localparam int unsigned P_ADC = 5;
   localparam int unsigned P_WDT = 6;
endpackage : ipr_pkg

//--- bench/ipr_checker_assertions.sv
// Port-level checks for the priority resolver.
// Assumes binding onto ipr_resolver; sees only its ports.
`timescale 1ns/1ps
module ipr_checker #(
   parameter int unsigned NUM_SRC = 19
) (
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic [7:0]         addr,
   input  wire logic               rd,
   input  wire logic               wr,
   input  wire logic               bit_wr,
   input  wire logic [NUM_SRC-1:0] src_enable,
   input  wire logic               vec_ack,
   input  wire logic               ret_done,
   input  wire logic               irq_req,
   input  wire logic [4:0]         irq_vector,
   input  wire logic               irq_high,
   input  wire logic [7:0]         rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside read cycle");
   main_rsvd_a: assert property ($past(rd) && $past(addr) == ipr_pkg::ADDR_MAIN
      |-> rdata[7:6] == 2'b00) else $error("main reserved bits not zero");
   ext_rsvd_a: assert property ($past(rd) && $past(addr) == ipr_pkg::ADDR_EXT
      |-> rdata[7:5] == 3'b000) else $error("ext reserved bits not zero");
   periph_rsvd_a: assert property ($past(rd) && $past(addr) == ipr_pkg::ADDR_PERIPH
      |-> !rdata[7]) else $error("periph reserved bit not zero");
   unmapped_read_a: assert property ($past(rd) && !($past(addr) inside {8'hB1, 8'hB8,
      8'hC1, 8'hC3}) |-> rdata == 8'h00) else $error("unmapped read not zero");
   high_block_a: assert property (vec_ack && irq_req && irq_high && !ret_done
      |=> !irq_req) else $error("request offered during high service");
   low_nest_a: assert property (vec_ack && irq_req && !irq_high && !ret_done
      |=> !irq_req || irq_high) else $error("low request offered during low service");
   req_hold_a: assert property (irq_req && !vec_ack && !wr && !bit_wr &&
      (irq_vector < 5'd4 || irq_vector > 5'd5)
      |=> irq_req || src_enable != $past(src_enable)) else $error("request dropped unacked");
   cover property (vec_ack && irq_req && irq_high);
   cover property (vec_ack && irq_req && !irq_high);
   cover property (bit_wr);
endmodule : ipr_checker

//--- bench/ipr_core_model.sv
// Core model: acks an offered request after a lag, returns on command.
// Assumes the bench pulses take and give_back for one cycle each.
`timescale 1ns/1ps
module ipr_core_model (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       irq_req,
   input  wire logic       take,
   input  wire logic [3:0] lag,
   input  wire logic       give_back,
   output logic            vec_ack,
   output logic            ret_done
);
   logic [3:0] cnt_q;
   logic       busy_q;
   logic [1:0] depth_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         {vec_ack, ret_done, busy_q, cnt_q, depth_q} <= '0;
      end else begin
         vec_ack  <= busy_q && cnt_q == 4'h0 && irq_req && !vec_ack;
         ret_done <= give_back && depth_q != 2'h0;
         busy_q   <= take || (busy_q && !vec_ack);
         cnt_q    <= take ? lag : (cnt_q != 4'h0 ? cnt_q - 4'h1 : cnt_q);
         depth_q  <= depth_q + {1'b0, vec_ack} - {1'b0, ret_done};
      end
   end
endmodule : ipr_core_model

//--- bench/testbench.sv
// Self-checking bench for the priority resolver and a core model.
// Assumes a 50 ns clock; all stimulus by non-blocking assignment.
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, bit_wr = 1'b0;
   logic        bit_val = 1'b0, take = 1'b0, give_back = 1'b0;
   logic        t2o = 1'b0, t2r = 1'b0, s0r = 1'b0, s0t = 1'b0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00;
   logic [2:0]  bit_num = 3'h0;
   logic [3:0]  lag = 4'h0;
   logic [18:0] src_event = '0, src_enable = '0;
   wire  [7:0]  rdata;
   wire  [4:0]  irq_vector;
   wire         irq_req, irq_high, vec_ack, ret_done;
   int          failures = 0, compares = 0;
   always #25 clk = ~clk;
   ipr_resolver #(.NUM_SRC(19)) u_ipr_resolver (.clk, .reset, .addr, .wdata, .wr, .rd,
      .bit_wr, .bit_num, .bit_val, .rdata, .src_event, .src_enable,
      .timer2_overflow_flag(t2o), .timer2_reload_flag(t2r), .serial0_receive_flag(s0r),
      .serial0_transmit_flag(s0t), .vec_ack, .ret_done, .irq_req, .irq_vector, .irq_high);
   ipr_core_model u_ipr_core_model (.clk, .reset, .irq_req, .take, .lag, .give_back,
      .vec_ack, .ret_done);
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) check(rdata, e);
      @(posedge clk);
   endtask : rd_chk
   task automatic bit_put(input logic [2:0] n, input logic v);
      addr <= ipr_pkg::ADDR_MAIN;
      bit_num <= n;
      bit_val <= v;
      bit_wr <= 1'b1;
      @(posedge clk) bit_wr <= 1'b0;
      @(posedge clk);
   endtask : bit_put
   task automatic fire(input logic [18:0] m);
      src_event <= m;
      @(posedge clk) src_event <= '0;
      repeat (2) @(posedge clk);
   endtask : fire
   task automatic serve(input logic [4:0] v, input logic h);
      take <= 1'b1;
      @(posedge clk) take <= 1'b0;
      repeat (40) @(negedge clk) if (vec_ack === 1'b1) break;
      check({7'h00, vec_ack}, 8'h01);
      check({3'h0, irq_vector}, {3'h0, v});
      check({7'h00, irq_high}, {7'h00, h});
      @(posedge clk) if (v == 5'd4) {s0r, s0t} <= 2'b00;
      if (v == 5'd5) {t2o, t2r} <= 2'b00;
      @(posedge clk);
   endtask : serve
   task automatic ret();
      give_back <= 1'b1;
      @(posedge clk) give_back <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : ret
   task automatic give_verdict();
      $display("Compares %0d, failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   initial begin
      #200000;
      failures++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 8; i++) rd_chk(8'hB1 + 8'(i % 3) * 8'h10, 8'h00);
      rd_chk(8'hB8, 8'h00);
      wr_reg(8'hB8, 8'hFF);
      rd_chk(8'hB8, 8'h3F);
      wr_reg(8'hB1, 8'hFF);
      rd_chk(8'hB1, 8'h1F);
      wr_reg(8'hC1, 8'hFF);
      rd_chk(8'hC1, 8'h7F);
      wr_reg(8'h00, 8'hFF);
      rd_chk(8'h00, 8'h00);
      wr_reg(8'hB1, 8'h00);
      wr_reg(8'hC1, 8'h00);
      wr_reg(8'hB8, 8'h00);
      bit_put(3'd3, 1'b1);
      rd_chk(8'hB8, 8'h08);
      bit_put(3'd3, 1'b0);
      src_enable <= 19'h7FFFF;
      {t2r, s0t} <= 2'b11;
      fire(19'h7FFCF);
      for (int i = 0; i < 19; i++) begin
         lag <= 4'(i);
         serve(5'(i), 1'b0);
         ret();
      end
      check({7'h00, irq_req}, 8'h00);
      bit_put(3'd1, 1'b1);
      fire(19'h00008);
      serve(5'd3, 1'b0);
      fire(19'h00002);
      serve(5'd1, 1'b1);
      fire(19'h00001);
      check({7'h00, irq_req}, 8'h00);
      rd_chk(8'hC3, 8'hC1);
      ret();
      check({7'h00, irq_req}, 8'h00);
      ret();
      serve(5'd0, 1'b0);
      ret();
      // Disabled source stays pending but is not offered
      src_enable <= 19'h7FFF7;
      fire(19'h00008);
      check({7'h00, irq_req}, 8'h00);
      // Other halves of the ORed sources
      src_enable <= 19'h7FFFF;
      {t2o, s0r} <= 2'b11;
      serve(5'd3, 1'b0);
      ret();
      serve(5'd4, 1'b0);
      ret();
      serve(5'd5, 1'b0);
      ret();
      check({7'h00, irq_req}, 8'h00);
      give_verdict();
   end
endmodule : testbench
bind ipr_resolver ipr_checker #(.NUM_SRC(NUM_SRC)) u_ipr_checker (.clk, .reset, .addr,
   .rd, .wr, .bit_wr, .src_enable, .vec_ack, .ret_done, .irq_req, .irq_vector,
   .irq_high, .rdata);
